/* src/bfwr_regs.sv */
// Forwarding window register bank with APB slave and window hit decoder
//
// What this block does
// - A memory transaction is forwarded only when its address lies inside the memory window or the prefetch window.
// - The memory bottom field in bits 15:4 gives address bits 31:20 of the bottom, low 20 bits zero.
// - The memory top field in bits 31:20 gives address bits 31:20 of the top, low 20 bits all ones.
// - The prefetch bottom field in bits 15:4 gives bits 31:20 and bits 3:0 read 0001 for 64-bit.
// - The prefetch top field in bits 31:20 gives bits 31:20 and bits 19:16 read 0001 for 64-bit.
// - A 32-bit read-write register holds bits 63:32 of the prefetch bottom and clears on reset.
// - A 32-bit read-write register holds bits 63:32 of the prefetch top and clears on reset.
// - A 16-bit read-write field in bits 15:0 holds bits 31:16 of the I/O bottom and clears on reset.
// - A 16-bit read-write field in bits 31:16 holds bits 31:16 of the I/O top and clears on reset.
// - The I/O top nibble gives bits 15:12 of the top and bits 11:0 are taken as all ones.
`timescale 1ns/1ns
module bfwr_regs (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [bfwr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [bfwr_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                pstrb,
  output logic [bfwr_pkg::DATA_W-1:0]    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire bfwr_pkg::bfwr_lookup_type lookup,
  output bfwr_pkg::bfwr_result_type      result
);
  import bfwr_pkg::*;

  // ==========================================================================
  // Storage
  logic [11:0] mem_bottom_reg;
  logic [11:0] mem_top_reg;
  logic [11:0] pref_bottom_low_reg;
  logic [11:0] pref_top_low_reg;
  logic [31:0] pref_bottom_high_reg;
  logic [31:0] pref_top_high_reg;
  logic [15:0] io_bottom_high_reg;
  logic [15:0] io_top_high_reg;
  logic [3:0]  io_bottom_nib_reg;
  logic [3:0]  io_top_nib_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  bfwr_result_type result_reg;

  // ==========================================================================
  // Helpers
  // Byte-lane merge of a write into the current word image
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0]  strb);
    logic [31:0] merged;
    merged = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merged[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return merged;
  endfunction

  // Offset decode, used at setup for the error flag, which in turn blocks the write access
  function automatic logic offset_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      IO_WINDOW_LOW_OFF, MEMORY_WINDOW_OFF, PREFETCH_WINDOW_LOW_OFF,
      PREFETCH_BOTTOM_HIGH_OFF, PREFETCH_TOP_HIGH_OFF, IO_WINDOW_HIGH_OFF: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ==========================================================================
  // Word images as seen by software
  logic [31:0] io_low_word;
  logic [31:0] mem_word;
  logic [31:0] pref_low_word;
  logic [31:0] io_high_word;
  logic [31:0] read_word;

  // Read-only indicators are forced here, so writes can never disturb them
  always_comb begin
    mem_word = {mem_top_reg, RESERVED_NIB, mem_bottom_reg, RESERVED_NIB};
    pref_low_word = {pref_top_low_reg, ADDR64_IND, pref_bottom_low_reg, ADDR64_IND};
    io_low_word = {16'h0000, io_top_nib_reg, IO32_IND, io_bottom_nib_reg, IO32_IND};
    io_high_word = {io_top_high_reg, io_bottom_high_reg};
  end

  // Read multiplexer
  always_comb begin
    case (paddr)
      IO_WINDOW_LOW_OFF: begin
        read_word = io_low_word;
      end
      MEMORY_WINDOW_OFF: begin
        read_word = mem_word;
      end
      PREFETCH_WINDOW_LOW_OFF: begin
        read_word = pref_low_word;
      end
      PREFETCH_BOTTOM_HIGH_OFF: begin
        read_word = pref_bottom_high_reg;
      end
      PREFETCH_TOP_HIGH_OFF: begin
        read_word = pref_top_high_reg;
      end
      IO_WINDOW_HIGH_OFF: begin
        read_word = io_high_word;
      end
      default: begin
        read_word = WORD_RESET;
      end
    endcase
  end

  // ==========================================================================
  // APB handshake
  logic setup_phase;
  logic write_access;
  logic [31:0] write_word;

  assign setup_phase  = psel && !penable;
  assign write_access = psel && penable && pwrite && !pslverr_reg;
  assign write_word   = merge_lanes(read_word, pwdata, pstrb);
  // One fixed wait-free access phase; read data is latched during setup
  assign pready  = psel && penable;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // Read data and error captured at setup so outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= WORD_RESET;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= pwrite ? WORD_RESET : read_word;
      pslverr_reg <= !offset_mapped(paddr);
    end
  end

  // ==========================================================================
  // Writable fields
  // Memory window fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_bottom_reg <= FIELD12_RESET;
      mem_top_reg    <= FIELD12_RESET;
    end else if (write_access && paddr == MEMORY_WINDOW_OFF) begin
      mem_bottom_reg <= write_word[BOTTOM_FIELD_LSB +: 12];
      mem_top_reg    <= write_word[TOP_FIELD_LSB +: 12];
    end
  end

  // Prefetch window low fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pref_bottom_low_reg <= FIELD12_RESET;
      pref_top_low_reg    <= FIELD12_RESET;
    end else if (write_access && paddr == PREFETCH_WINDOW_LOW_OFF) begin
      pref_bottom_low_reg <= write_word[BOTTOM_FIELD_LSB +: 12];
      pref_top_low_reg    <= write_word[TOP_FIELD_LSB +: 12];
    end
  end

  // Prefetch window upper halves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pref_bottom_high_reg <= WORD_RESET;
      pref_top_high_reg    <= WORD_RESET;
    end else if (write_access) begin
      if (paddr == PREFETCH_BOTTOM_HIGH_OFF) begin
        pref_bottom_high_reg <= write_word;
      end
      if (paddr == PREFETCH_TOP_HIGH_OFF) begin
        pref_top_high_reg <= write_word;
      end
    end
  end

  // I/O window fields, both words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_bottom_high_reg <= HALF_RESET;
      io_top_high_reg    <= HALF_RESET;
      io_bottom_nib_reg  <= NIB_RESET;
      io_top_nib_reg     <= NIB_RESET;
    end else if (write_access) begin
      if (paddr == IO_WINDOW_HIGH_OFF) begin
        io_bottom_high_reg <= write_word[IO_HIGH_BOTTOM_LSB +: 16];
        io_top_high_reg    <= write_word[IO_HIGH_TOP_LSB +: 16];
      end
      if (paddr == IO_WINDOW_LOW_OFF) begin
        io_bottom_nib_reg <= write_word[IO_BOTTOM_NIB_LSB +: 4];
        io_top_nib_reg    <= write_word[IO_TOP_NIB_LSB +: 4];
      end
    end
  end

  // ==========================================================================
  // Window bounds
  logic [31:0] mem_bottom;
  logic [31:0] mem_top;
  logic [63:0] pref_bottom;
  logic [63:0] pref_top;
  logic [31:0] io_bottom;
  logic [31:0] io_top;

  // Implied low bits joined onto the programmed fields
  always_comb begin
    mem_bottom = {mem_bottom_reg, MEM_LOW_ZERO};
    mem_top = {mem_top_reg, MEM_LOW_ONES};
    pref_bottom = {pref_bottom_high_reg, pref_bottom_low_reg, MEM_LOW_ZERO};
    pref_top = {pref_top_high_reg, pref_top_low_reg, MEM_LOW_ONES};
    io_bottom = {io_bottom_high_reg, io_bottom_nib_reg, IO_LOW_ZERO};
    io_top = {io_top_high_reg, io_top_nib_reg, IO_LOW_ONES};
  end

  // ==========================================================================
  // Hit decode, registered one cycle after the lookup
  logic mem_inside;
  logic pref_inside;
  logic io_inside;

  // Inclusive compares; a bottom above the top simply never hits
  always_comb begin
    mem_inside = lookup.addr[63:32] == 32'h0000_0000 &&
                 lookup.addr[31:0] >= mem_bottom && lookup.addr[31:0] <= mem_top;
    pref_inside = lookup.addr >= pref_bottom && lookup.addr <= pref_top;
    io_inside = lookup.addr[63:32] == 32'h0000_0000 &&
                lookup.addr[31:0] >= io_bottom && lookup.addr[31:0] <= io_top;
  end

  // Result flops; memory hits never fire for I/O lookups and vice versa
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= '0;
    end else begin
      result_reg.valid        <= lookup.valid;
      result_reg.mem_hit      <= lookup.valid && !lookup.is_io && mem_inside;
      result_reg.prefetch_hit <= lookup.valid && !lookup.is_io && pref_inside;
      result_reg.io_hit       <= lookup.valid && lookup.is_io && io_inside;
      result_reg.forward      <= lookup.valid &&
                                 (lookup.is_io ? io_inside : (mem_inside || pref_inside));
    end
  end

  assign result = result_reg;

  // ==========================================================================
  // Assertions
  a_mem_hit_bounds: assert property (@(posedge pclk) disable iff (!presetn)
    lookup.valid && !lookup.is_io |=> result.mem_hit ==
      ($past(lookup.addr[63:32]) == 32'h0000_0000 &&
       $past(lookup.addr[31:20]) >= $past(mem_bottom_reg) &&
       $past(lookup.addr[31:20]) <= $past(mem_top_reg)))
    else $error("memory window hit wrong");

  a_mem_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && paddr == MEMORY_WINDOW_OFF |=> prdata[3:0] == 4'h0 && pready)
    else $error("memory bottom reserved bits not zero");

  a_mem_top_edge: assert property (@(posedge pclk) disable iff (!presetn)
    lookup.valid && !lookup.is_io && lookup.addr == {32'h0, mem_top_reg, 20'hfffff} &&
    mem_bottom_reg <= mem_top_reg |=> result.mem_hit && result.forward)
    else $error("memory top address not inside window");

  a_pref_bottom_ind: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && paddr == PREFETCH_WINDOW_LOW_OFF |=> prdata[3:0] == 4'h1)
    else $error("prefetch bottom indicator wrong");

  a_pref_top_ind: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && paddr == PREFETCH_WINDOW_LOW_OFF |=> prdata[19:16] == 4'h1)
    else $error("prefetch top indicator wrong");

  a_pref_bottom_write: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && pstrb == 4'hf && paddr == PREFETCH_BOTTOM_HIGH_OFF
    |=> pref_bottom_high_reg == $past(pwdata))
    else $error("prefetch bottom upper word not written");

  a_pref_top_write: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && pstrb == 4'hf && paddr == PREFETCH_TOP_HIGH_OFF
    |=> pref_top_high_reg == $past(pwdata))
    else $error("prefetch top upper word not written");

  a_io_high_write: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && pstrb == 4'hf && paddr == IO_WINDOW_HIGH_OFF
    |=> io_bottom_high_reg == $past(pwdata[15:0]))
    else $error("upper I/O bottom not written");

  a_io_top_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && paddr == IO_WINDOW_HIGH_OFF |=> prdata[31:16] == $past(io_top_high_reg))
    else $error("upper I/O top read back wrong");

  a_io_top_edge: assert property (@(posedge pclk) disable iff (!presetn)
    lookup.valid && lookup.is_io && lookup.addr == {32'h0, io_top_high_reg, io_top_nib_reg, 12'hfff} &&
    io_bottom <= io_top |=> result.io_hit && result.forward)
    else $error("I/O top address not inside window");

  a_pref_bottom_edge: assert property (@(posedge pclk) disable iff (!presetn)
    lookup.valid && !lookup.is_io &&
    lookup.addr == {pref_bottom_high_reg, pref_bottom_low_reg, 20'h00000} &&
    pref_bottom <= pref_top |=> result.prefetch_hit && result.forward)
    else $error("prefetch bottom address not inside window");

  a_mem_bottom_edge: assert property (@(posedge pclk) disable iff (!presetn)
    lookup.valid && !lookup.is_io && lookup.addr == {32'h0, mem_bottom_reg, 20'h00000} &&
    mem_bottom_reg <= mem_top_reg |=> result.mem_hit && result.forward)
    else $error("memory bottom address not inside window");

  a_io_bottom_edge: assert property (@(posedge pclk) disable iff (!presetn)
    lookup.valid && lookup.is_io && lookup.addr == {32'h0, io_bottom_high_reg, io_bottom_nib_reg, 12'h000} &&
    io_bottom <= io_top |=> result.io_hit && result.forward)
    else $error("I/O bottom address not inside window");

  a_io_top_write: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && pstrb == 4'hf && paddr == IO_WINDOW_HIGH_OFF
    |=> io_top_high_reg == $past(pwdata[31:16]))
    else $error("upper I/O top not written");

endmodule

/* pkg/bfwr_pkg.sv */
// Package: register map, field layout, reset values and carriers of the bridge window registers
package bfwr_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] IO_WINDOW_LOW_OFF         = 8'h1c;
  localparam logic [7:0] MEMORY_WINDOW_OFF         = 8'h20;
  localparam logic [7:0] PREFETCH_WINDOW_LOW_OFF   = 8'h24;
  localparam logic [7:0] PREFETCH_BOTTOM_HIGH_OFF  = 8'h28;
  localparam logic [7:0] PREFETCH_TOP_HIGH_OFF     = 8'h2c;
  localparam logic [7:0] IO_WINDOW_HIGH_OFF        = 8'h30;

  // ==========================================================================
  // Field positions (least significant bit of each field)
  localparam int unsigned BOTTOM_FIELD_LSB   = 4;   // Bottom field, bits 15:4
  localparam int unsigned TOP_FIELD_LSB      = 20;  // Top field, bits 31:20
  localparam int unsigned BOTTOM_IND_LSB     = 0;   // Indicator, bits 3:0
  localparam int unsigned TOP_IND_LSB        = 16;  // Indicator, bits 19:16
  localparam int unsigned IO_BOTTOM_NIB_LSB  = 4;   // I/O bottom nibble, bits 7:4
  localparam int unsigned IO_TOP_IND_LSB     = 8;   // I/O top indicator, bits 11:8
  localparam int unsigned IO_TOP_NIB_LSB     = 12;  // I/O top nibble, bits 15:12
  localparam int unsigned IO_HIGH_BOTTOM_LSB = 0;   // Upper I/O bottom, bits 15:0
  localparam int unsigned IO_HIGH_TOP_LSB    = 16;  // Upper I/O top, bits 31:16

  // ==========================================================================
  // Fixed read-only values and reset values
  localparam logic [3:0]  ADDR64_IND     = 4'h1;
  localparam logic [3:0]  IO32_IND       = 4'h1;
  localparam logic [3:0]  RESERVED_NIB   = 4'h0;
  localparam logic [11:0] FIELD12_RESET  = 12'h000;
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
  localparam logic [15:0] HALF_RESET     = 16'h0000;
  localparam logic [3:0]  NIB_RESET      = 4'h0;

  // ==========================================================================
  // Implied low address bits
  localparam logic [19:0] MEM_LOW_ZERO = 20'h00000;
  localparam logic [19:0] MEM_LOW_ONES = 20'hfffff;
  localparam logic [11:0] IO_LOW_ZERO  = 12'h000;
  localparam logic [11:0] IO_LOW_ONES  = 12'hfff;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [63:0] addr;
  } bfwr_lookup_type;

  typedef struct packed {
    logic valid;
    logic mem_hit;
    logic prefetch_hit;
    logic io_hit;
    logic forward;
  } bfwr_result_type;

endpackage

/* testbench/bfwr_agent_model.sv */
// Far-side bus agent model that presents address lookups to the window decoder
`timescale 1ns/1ns
module bfwr_agent_model (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      req_valid,
  input  wire logic                      req_is_io,
  input  wire logic [63:0]               req_addr,
  output bfwr_pkg::bfwr_lookup_type      lookup
);
  import bfwr_pkg::*;

  // ==========================================================================
  // Lookup driver
  // Idle address keeps toggling so a stale address never passes as valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lookup <= '0;
    end else begin
      lookup.valid <= req_valid;
      lookup.is_io <= req_is_io;
      lookup.addr  <= req_valid ? req_addr : ~lookup.addr;
    end
  end
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the forwarding window register bank
`timescale 1ns/1ns
module testbench;
  import bfwr_pkg::*;

  // ==========================================================================
  // Signals and case tables
  typedef struct {logic w; logic [7:0] a; logic [3:0] s; logic [31:0] d; logic [31:0] e;} bfwr_reg_row_type;
  typedef struct {logic v; logic io; logic [63:0] a; logic m; logic p; logic i;} bfwr_look_row_type;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [3:0]      pstrb = 4'h0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic            req_valid = 1'b0;
  logic            req_is_io = 1'b0;
  logic [63:0]     req_addr = 64'h0;
  bfwr_lookup_type lookup;
  bfwr_result_type result;
  int              fail_count = 0;
  int              check_count = 0;
  logic [31:0]     rd;
  logic            err;
  logic [7:0]      zoff [4] = '{8'h28, 8'h2c, 8'h30, 8'h20};
  // Reset reads, field masks, a single-lane write, then the window setup
  bfwr_reg_row_type regs [16] = '{
    '{1'b0, 8'h20, 4'hf, 32'h0, 32'h0000_0000}, '{1'b0, 8'h24, 4'hf, 32'h0, 32'h0001_0001},
    '{1'b0, 8'h28, 4'hf, 32'h0, 32'h0000_0000}, '{1'b0, 8'h2c, 4'hf, 32'h0, 32'h0000_0000},
    '{1'b0, 8'h30, 4'hf, 32'h0, 32'h0000_0000}, '{1'b0, 8'h1c, 4'hf, 32'h0, 32'h0000_0101},
    '{1'b1, 8'h20, 4'hf, 32'hffff_ffff, 32'hfff0_fff0}, '{1'b1, 8'h24, 4'hf, 32'hffff_ffff, 32'hfff1_fff1},
    '{1'b1, 8'h28, 4'h1, 32'hffff_ffa5, 32'h0000_00a5}, '{1'b1, 8'h30, 4'hf, 32'hdead_beef, 32'hdead_beef},
    '{1'b1, 8'h20, 4'hf, 32'h1ff0_1000, 32'h1ff0_1000}, '{1'b1, 8'h24, 4'hf, 32'h2ff0_2000, 32'h2ff1_2001},
    '{1'b1, 8'h28, 4'hf, 32'h0000_0001, 32'h0000_0001}, '{1'b1, 8'h2c, 4'hf, 32'h0000_0001, 32'h0000_0001},
    '{1'b1, 8'h1c, 4'hf, 32'h0000_5030, 32'h0000_5131}, '{1'b1, 8'h30, 4'hf, 32'h0004_0004, 32'h0004_0004}};
  // Window edges one below and at each bottom, at and one above each top
  bfwr_look_row_type looks [14] = '{
    '{1'b0, 1'b0, 64'h1000_0000, 1'b0, 1'b0, 1'b0}, '{1'b1, 1'b0, 64'h0fff_ffff, 1'b0, 1'b0, 1'b0},
    '{1'b1, 1'b0, 64'h1000_0000, 1'b1, 1'b0, 1'b0}, '{1'b1, 1'b0, 64'h1fff_ffff, 1'b1, 1'b0, 1'b0},
    '{1'b1, 1'b0, 64'h2000_0000, 1'b0, 1'b0, 1'b0}, '{1'b1, 1'b0, 64'h1_1fff_ffff, 1'b0, 1'b0, 1'b0},
    '{1'b1, 1'b0, 64'h1_2000_0000, 1'b0, 1'b1, 1'b0}, '{1'b1, 1'b0, 64'h1_2fff_ffff, 1'b0, 1'b1, 1'b0},
    '{1'b1, 1'b0, 64'h1_3000_0000, 1'b0, 1'b0, 1'b0}, '{1'b1, 1'b1, 64'h4_2fff, 1'b0, 1'b0, 1'b0},
    '{1'b1, 1'b1, 64'h4_3000, 1'b0, 1'b0, 1'b1}, '{1'b1, 1'b1, 64'h4_5fff, 1'b0, 1'b0, 1'b1},
    '{1'b1, 1'b1, 64'h4_6000, 1'b0, 1'b0, 1'b0}, '{1'b1, 1'b1, 64'h1000_0000, 1'b0, 1'b0, 1'b0}};
  // Cleared windows span the lowest megabyte and the lowest 4 KB of I/O
  bfwr_look_row_type rlook [4] = '{
    '{1'b1, 1'b0, 64'h0, 1'b1, 1'b1, 1'b0}, '{1'b1, 1'b0, 64'h10_0000, 1'b0, 1'b0, 1'b0},
    '{1'b1, 1'b1, 64'hfff, 1'b0, 1'b0, 1'b1}, '{1'b1, 1'b1, 64'h1000, 1'b0, 1'b0, 1'b0}};

  // ==========================================================================
  // Clock, design and far-side agent
  always #4 pclk = ~pclk;
  bfwr_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lookup(lookup), .result(result));
  bfwr_agent_model u_agent (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
    .req_is_io(req_is_io), .req_addr(req_addr), .lookup(lookup));

  // ==========================================================================
  // Compare, bus and lookup tasks
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_res(input bfwr_result_type got, input bfwr_result_type exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t: result %b expected %b", $time, got, exp);
    end
  endtask

  // One APB transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pstrb <= s;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No cycle count assumed; only the watchdog ends a hung slave
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Result is read at the edge that closes the cycle in which it stands
  task automatic look(input bfwr_look_row_type r);
    req_valid <= r.v;
    req_is_io <= r.io;
    req_addr <= r.a;
    @(posedge pclk);
    req_valid <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk_res(result, '{r.v, r.m, r.p, r.i, r.m | r.p | r.i});
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[k]) begin
      if (regs[k].w) begin
        apb(1'b1, regs[k].a, regs[k].s, regs[k].d);
      end
      apb(1'b0, regs[k].a, 4'hf, 32'h0);
      chk32(rd, regs[k].e);
      chk32({31'h0, err}, 32'h0);
    end
    foreach (looks[k]) begin
      look(looks[k]);
    end
    // Unmapped and misaligned places answer with an error
    apb(1'b1, 8'h34, 4'hf, 32'hffff_ffff);
    chk32({31'h0, err}, 32'h1);
    apb(1'b0, 8'h21, 4'hf, 32'h0);
    chk32({31'h0, err}, 32'h1);
    // Reset in mid-run clears every writable field
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (zoff[k]) begin
      apb(1'b0, zoff[k], 4'hf, 32'h0);
      chk32(rd, 32'h0);
    end
    foreach (rlook[k]) begin
      look(rlook[k]);
    end
    finish_test();
  end

  // Watchdog well beyond the fewer than two hundred cycles the sequence needs
  initial begin
    #80000;
    fail_count++;
    finish_test();
  end
endmodule
